// ### hw/oscal_top.sv
// oscillator calibration counter: apb registers, sequencer, counters, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "oscal_cfg.svh"

// Operation
// - a one written to the start bit begins a run with the selected oscillator and count.
// - the start bit goes back to zero only when the run is over and the result is valid.
// - the two-bit select picks slow rc (0), fast rc (1), slow crystal (2) or slow rcx (3).
// - the 16-bit window count is loaded into a reference-clocked down-counter; run ends at one.
// - crystal cycles in the window are counted and the low half is read from one register.
// - the high half of the same 32-bit count is read from a second register.
module oscal_top (
  input  wire logic        clk,      // fast crystal clock
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  ref_osc,  // slow rc, fast rc, slow crystal, slow rcx
  output logic             irq
);
  import oscal_pkg::*;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  oscal_regbus_if bus ();

  oscal_state_type          state_q;
  oscal_refsel_type         sel_q;      // software select
  oscal_refsel_type         run_sel_q;  // select held for the run
  logic [`OSCAL_REG_W-1:0]  window_q;
  logic [`OSCAL_REG_W-1:0]  down_q;
  logic [31:0]              xtal_q;
  logic [`OSCAL_EVT_W-1:0]  stat_q;
  logic [`OSCAL_EVT_W-1:0]  en_q;
  logic                     irq_q;
  logic                     ref_rise;
  logic                     busy;
  logic                     wr_ctrl;
  logic                     start_req;
  logic                     start_ok;
  logic                     refused;
  logic                     run_end;
  logic [`OSCAL_EVT_W-1:0]  evt;

  // --------------------------------------------------------------------------
  // sub-blocks
  // --------------------------------------------------------------------------
  // register bus front end; pready is tied high, so every access takes two cycles, setup and access
  oscal_apb_slave u_apb (
    .clk     (clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.slave)
  );

  // the references pass two flops before the edge finder; the latency is the same
  // at both ends of the window, so it cancels out of the result
  oscal_ref_sync u_ref (
    .clk      (clk),
    .rst_b    (rst_b),
    .ref_osc  (ref_osc),
    .sel      (run_sel_q),
    .ref_rise (ref_rise)
  );

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // a start while busy is refused and flagged, it never restarts the run
  assign busy      = (state_q != OSCAL_IDLE);
  assign wr_ctrl   = bus.wr & (bus.rsel == OSCAL_REG_CTRL);
  assign start_req = wr_ctrl & bus.wdata[`OSCAL_START_BIT];
  assign start_ok  = start_req & ~busy;
  assign refused   = start_req & busy;
  assign run_end   = (state_q == OSCAL_MEAS) & ref_rise & (down_q <= 16'h0001);

  // events into the sticky status
  always_comb begin
    evt                      = `OSCAL_EVT_RST;
    evt[`OSCAL_EVT_DONE]     = run_end;
    evt[`OSCAL_EVT_REFUSED]  = refused;
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // reference select and window length
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q    <= oscal_refsel_type'(`OSCAL_SEL_RST);
      window_q <= `OSCAL_WIN_RST;
    end else if (bus.wr) begin
      if (bus.rsel == OSCAL_REG_CTRL) begin
        sel_q <= oscal_refsel_type'(bus.wdata[`OSCAL_SEL_MSB:`OSCAL_SEL_LSB]);
      end
      if (bus.rsel == OSCAL_REG_WIN) begin
        window_q <= bus.wdata[`OSCAL_REG_W-1:0];
      end
    end
  end

  // interrupt enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= `OSCAL_EVT_RST;
    end else if (bus.wr & (bus.rsel == OSCAL_REG_EN)) begin
      en_q <= bus.wdata[`OSCAL_EVT_W-1:0];
    end
  end

  // sticky status: write-one-to-clear, a new event wins over its clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= `OSCAL_EVT_RST;
    end else if (bus.wr & (bus.rsel == OSCAL_REG_CLR)) begin
      stat_q <= (stat_q & ~bus.wdata[`OSCAL_EVT_W-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  // level interrupt, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= |(stat_q & en_q);
    end
  end

  assign irq = irq_q;

  // --------------------------------------------------------------------------
  // measurement sequencer
  // --------------------------------------------------------------------------
  // idle -> arm (wait first reference edge) -> measure -> idle
  // counting opens on a reference edge, not on the bus write, so the window
  // always spans whole reference periods and carries no phase error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= OSCAL_IDLE;
    end else begin
      unique case (state_q)
        OSCAL_IDLE: begin
          if (start_ok) begin
            state_q <= OSCAL_ARM;
          end
        end
        OSCAL_ARM: begin
          if (ref_rise) begin
            state_q <= OSCAL_MEAS;
          end
        end
        OSCAL_MEAS: begin
          if (run_end) begin
            state_q <= OSCAL_IDLE;
          end
        end
        default: begin
          state_q <= OSCAL_IDLE;
        end
      endcase
    end
  end

  // the select is frozen at start using the value of the same write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_sel_q <= oscal_refsel_type'(`OSCAL_SEL_RST);
    end else if (start_ok) begin
      run_sel_q <= oscal_refsel_type'(bus.wdata[`OSCAL_SEL_MSB:`OSCAL_SEL_LSB]);
    end
  end

  // reference-edge down-counter
  // a zero window behaves as a window of one, since the run ends at one or below
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      down_q <= `OSCAL_WIN_RST;
    end else if ((state_q == OSCAL_ARM) & ref_rise) begin
      down_q <= window_q;
    end else if ((state_q == OSCAL_MEAS) & ref_rise & ~run_end) begin
      down_q <= down_q - 16'h0001;
    end
  end

  // crystal cycle counter, held after the run as the result
  // it wraps at 32 bits; a window long enough to wrap is a limit for software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_q <= `OSCAL_RES_RST;
    end else if (start_ok) begin
      xtal_q <= `OSCAL_RES_RST;
    end else if (state_q == OSCAL_MEAS) begin
      xtal_q <= xtal_q + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  // results read live during a run; they settle once the start bit reads zero
  always_comb begin
    bus.rdata = 32'h0000_0000;
    unique case (bus.rsel)
      OSCAL_REG_CTRL: begin
        bus.rdata[`OSCAL_START_BIT]              = busy;
        bus.rdata[`OSCAL_SEL_MSB:`OSCAL_SEL_LSB] = sel_q;
      end
      OSCAL_REG_WIN:  bus.rdata[`OSCAL_REG_W-1:0] = window_q;
      OSCAL_REG_RESL: bus.rdata[15:0]             = xtal_q[15:0];
      OSCAL_REG_RESH: bus.rdata[15:0]             = xtal_q[31:16];
      OSCAL_REG_STAT: bus.rdata[`OSCAL_EVT_W-1:0] = stat_q;
      OSCAL_REG_EN:   bus.rdata[`OSCAL_EVT_W-1:0] = en_q;
      OSCAL_REG_CLR:  bus.rdata = 32'h0000_0000;
      OSCAL_REG_NONE: bus.rdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_START_ARMS: assert property (
    start_ok |=> (state_q == OSCAL_ARM) && (xtal_q == 32'h0000_0000) && busy
  ) else $error("start did not arm a run");

  AST_START_ONLY_WHEN_DONE: assert property (
    $fell(busy) |-> $past(run_end) && stat_q[`OSCAL_EVT_DONE]
  ) else $error("start bit cleared before run end");

  AST_END_STOPS: assert property (
    run_end |=> !busy ##1 (!busy || $past(start_ok))
  ) else $error("run did not stop at window end");

  AST_SEL_HELD: assert property (
    (state_q == OSCAL_MEAS) && $past(state_q == OSCAL_MEAS) |-> $stable(run_sel_q)
  ) else $error("reference select moved during run");

  AST_WINDOW_LOAD: assert property (
    (state_q == OSCAL_ARM) && ref_rise |=> (down_q == $past(window_q))
      && (state_q == OSCAL_MEAS)
  ) else $error("window count not loaded on first edge");

  AST_DOWN_STEP: assert property (
    (state_q == OSCAL_MEAS) && ref_rise && (down_q > 16'h0001)
      |=> (down_q == $past(down_q) - 16'h0001) && busy
  ) else $error("down-counter did not step");

  AST_COUNT_STEP: assert property (
    (state_q == OSCAL_MEAS) |=> (xtal_q == $past(xtal_q) + 32'h0000_0001)
  ) else $error("crystal count did not advance");

  AST_RESULT_HELD: assert property (
    !busy && $past(!busy) && !start_ok |=> $stable(xtal_q)
  ) else $error("result moved while idle");

  AST_BUSY_READ: assert property (
    (bus.rsel == OSCAL_REG_CTRL) |-> (bus.rdata[`OSCAL_START_BIT] == busy)
      && (bus.rdata[31:`OSCAL_START_BIT+1] == 29'h0000_0000)
  ) else $error("start bit does not mirror run");

  AST_IRQ_LEVEL: assert property (
    |(stat_q & en_q) |=> irq
  ) else $error("enabled status did not raise irq");

  AST_IRQ_CLEAR: assert property (
    !(|(stat_q & en_q)) |=> !irq
  ) else $error("irq stayed high with no enabled status");

  AST_REFUSED_FLAG: assert property (
    refused |=> stat_q[`OSCAL_EVT_REFUSED]
  ) else $error("refused start was not flagged");

  AST_DONE_FLAG: assert property (
    run_end |=> stat_q[`OSCAL_EVT_DONE] && !busy
  ) else $error("run end did not flag done");

  AST_ARM_NO_COUNT: assert property (
    (state_q == OSCAL_ARM) && !ref_rise
      |=> (state_q == OSCAL_ARM) && (xtal_q == 32'h0000_0000)
  ) else $error("crystal count ran before the window opened");

  COV_RUN_DONE:  cover property (start_ok ##[1:1000] run_end);
  COV_REFUSED:   cover property (refused);
  COV_IRQ:       cover property ($rose(irq));
  COV_LONG_RUN:  cover property ((state_q == OSCAL_MEAS) && ref_rise && (down_q > 16'h0001));
  COV_ZERO_WIN:  cover property ((state_q == OSCAL_ARM) && ref_rise && (window_q == 16'h0000));

endmodule : oscal_top

`default_nettype wire

// ### hw/oscal_cfg.svh
// register map, field positions and reset values of the oscillator calibration counter
`ifndef OSCAL_CFG_SVH
`define OSCAL_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define OSCAL_CTRL_IDX     32'h5000_1600
`define OSCAL_WIN_IDX      32'h5000_1602
`define OSCAL_RESL_IDX     32'h5000_1604
`define OSCAL_RESH_IDX     32'h5000_1606
`define OSCAL_STAT_IDX     32'h5000_1608
`define OSCAL_CLR_IDX      32'h5000_160A
`define OSCAL_EN_IDX       32'h5000_160C

// low twelve byte-address bits that the slave decodes
`define OSCAL_ADDR(i)      (12'((i) << 2))

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define OSCAL_REG_W        16
`define OSCAL_START_BIT    2
`define OSCAL_SEL_MSB      1
`define OSCAL_SEL_LSB      0
`define OSCAL_EVT_W        2
`define OSCAL_EVT_DONE     0
`define OSCAL_EVT_REFUSED  1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define OSCAL_SEL_RST      2'h0
`define OSCAL_WIN_RST      16'h0000
`define OSCAL_RES_RST      32'h0000_0000
`define OSCAL_EVT_RST      2'h0

`endif

// ### hw/oscal_pkg.sv
// types shared by the oscillator calibration counter modules
package oscal_pkg;

  // measurement sequencer states
  typedef enum logic [2:0] {
    OSCAL_IDLE = 3'b001,
    OSCAL_ARM  = 3'b010,
    OSCAL_MEAS = 3'b100
  } oscal_state_type;

  // decoded register select
  typedef enum logic [2:0] {
    OSCAL_REG_CTRL,
    OSCAL_REG_WIN,
    OSCAL_REG_RESL,
    OSCAL_REG_RESH,
    OSCAL_REG_STAT,
    OSCAL_REG_CLR,
    OSCAL_REG_EN,
    OSCAL_REG_NONE
  } oscal_reg_type;

  // reference oscillator codes
  typedef enum logic [1:0] {
    OSCAL_SLOW_RC_OSCILLATOR      = 2'h0,
    OSCAL_FAST_RC_OSCILLATOR      = 2'h1,
    OSCAL_SLOW_CRYSTAL_OSCILLATOR = 2'h2,
    OSCAL_SLOW_RCX_OSCILLATOR     = 2'h3
  } oscal_refsel_type;

endpackage : oscal_pkg

// ### hw/oscal_regbus_if.sv
// register access strobes between the bus slave and the calibration core
`timescale 1ns/1ps
`default_nettype none

interface oscal_regbus_if;
  oscal_pkg::oscal_reg_type rsel;   // decoded register of the current transfer
  logic                     wr;     // write takes effect this edge
  logic [31:0]              wdata;  // write data
  logic [31:0]              rdata;  // read value of the selected register

  modport slave (output rsel, output wr, output wdata, input rdata);
  modport core  (input rsel, input wr, input wdata, output rdata);
endinterface : oscal_regbus_if

`default_nettype wire

// ### hw/oscal_apb_slave.sv
// apb slave front end of the oscillator calibration counter
`timescale 1ns/1ps
`default_nettype none
`include "oscal_cfg.svh"

module oscal_apb_slave (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  oscal_regbus_if.slave    bus
);
  import oscal_pkg::*;

  logic [31:0] prdata_q;

  // map the low address bits onto a register
  function automatic oscal_reg_type decode_addr(input logic [11:0] a);
    unique case (a)
      `OSCAL_ADDR(`OSCAL_CTRL_IDX): decode_addr = OSCAL_REG_CTRL;
      `OSCAL_ADDR(`OSCAL_WIN_IDX):  decode_addr = OSCAL_REG_WIN;
      `OSCAL_ADDR(`OSCAL_RESL_IDX): decode_addr = OSCAL_REG_RESL;
      `OSCAL_ADDR(`OSCAL_RESH_IDX): decode_addr = OSCAL_REG_RESH;
      `OSCAL_ADDR(`OSCAL_STAT_IDX): decode_addr = OSCAL_REG_STAT;
      `OSCAL_ADDR(`OSCAL_CLR_IDX):  decode_addr = OSCAL_REG_CLR;
      `OSCAL_ADDR(`OSCAL_EN_IDX):   decode_addr = OSCAL_REG_EN;
      default:                      decode_addr = OSCAL_REG_NONE;
    endcase
  endfunction : decode_addr

  // decode and strobes; writes land on the access edge, no wait states
  assign bus.rsel  = decode_addr(paddr[11:0]);
  assign bus.wr    = psel & penable & pwrite & (bus.rsel != OSCAL_REG_NONE);
  assign bus.wdata = pwdata;
  assign pready    = 1'h1;
  assign pslverr   = psel & penable & (bus.rsel == OSCAL_REG_NONE);
  assign prdata    = prdata_q;

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= bus.rdata;
    end
  end

endmodule : oscal_apb_slave

`default_nettype wire

// ### hw/oscal_ref_sync.sv
// synchroniser and rising-edge finder for the four reference oscillators
`timescale 1ns/1ps
`default_nettype none

module oscal_ref_sync (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [3:0]              ref_osc,
  input  wire oscal_pkg::oscal_refsel_type sel,
  output logic                         ref_rise
);
  import oscal_pkg::*;

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] last_q;

  // two flops per oscillator, then one more for the edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      last_q <= 4'h0;
    end else begin
      meta_q <= ref_osc;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // edges are found per channel so a select change makes no false edge
  assign ref_rise = sync_q[sel] & ~last_q[sel];

endmodule : oscal_ref_sync

`default_nettype wire

// ### testbench/tb_oscillator_calibration_counter.sv
// self-checking testbench of the oscillator calibration counter
`timescale 1ns/1ps
`default_nettype none
`include "oscal_cfg.svh"

module tb_oscillator_calibration_counter;
  import oscal_pkg::*;

  // ----------------------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------------------
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ref_osc = 4'h0;
  logic        irq;
  int          miscompares;
  int          comparisons;
  logic [45:0] expect_q[$];               // skip flag, address, error flag, read data
  logic [45:0] note;
  string       what;
  int          half_per[4] = '{8, 3, 5, 7}; // half periods of the references in clk cycles
  int          ref_cnt[4]  = '{0, 0, 0, 0};

  localparam logic [11:0] A_CTRL = `OSCAL_ADDR(`OSCAL_CTRL_IDX);
  localparam logic [11:0] A_WIN  = `OSCAL_ADDR(`OSCAL_WIN_IDX);
  localparam logic [11:0] A_RESL = `OSCAL_ADDR(`OSCAL_RESL_IDX);
  localparam logic [11:0] A_RESH = `OSCAL_ADDR(`OSCAL_RESH_IDX);
  localparam logic [11:0] A_STAT = `OSCAL_ADDR(`OSCAL_STAT_IDX);
  localparam logic [11:0] A_CLR  = `OSCAL_ADDR(`OSCAL_CLR_IDX);
  localparam logic [11:0] A_EN   = `OSCAL_ADDR(`OSCAL_EN_IDX);

  oscal_top oscal_top_inst (
    .clk     (clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ref_osc (ref_osc),
    .irq     (irq)
  );

  // ----------------------------------------------------------------------------
  // clock, reference oscillators and watchdog
  // ----------------------------------------------------------------------------
  // 10 MHz crystal clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // four free-running references, each an exact number of clk cycles long
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (ref_cnt[i] == half_per[i] - 1) begin
        ref_cnt[i] <= 0;
        ref_osc[i] <= ~ref_osc[i];
      end else begin
        ref_cnt[i] <= ref_cnt[i] + 1;
      end
    end
  end

  // cuts a hang short well after the longest run should be over
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------------------
  // comparison and read monitor
  // ----------------------------------------------------------------------------
  task automatic check(input string what_s, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what_s, exp, seen);
    end
  endtask : check

  // each completed read takes the oldest note off the queue
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expect_q.size() > 0) begin
        note = expect_q.pop_front();
        $sformat(what, "read of %h", note[44:33]);
        if (note[45] === 1'b0) begin
          check(what, {pslverr, prdata}, note[32:0]);  // oldest note against the bus
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // apb master tasks
  // ----------------------------------------------------------------------------
  task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {20'($urandom), addr};  // upper address bits are not decoded
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    apb(1'b1, addr, wd, rd);
  endtask : wr

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic err);
    logic [31:0] rd;
    expect_q.push_back({1'b0, addr, err, exp});
    apb(1'b0, addr, 32'h0000_0000, rd);
  endtask : rd_chk

  // one full run: program, start, wait for the start bit to drop, check all results
  task automatic run(input int sel, input int w, input logic [31:0] en, input logic refuse);
    logic [31:0] rd;
    int          n;
    int          res;
    res = (w == 0 ? 1 : w) * 2 * half_per[sel];
    wr(A_EN, en);
    wr(A_WIN, 32'(w));
    wr(A_CTRL, 32'h0000_0004 | 32'(sel));
    rd_chk(A_CTRL, 32'h0000_0004 | 32'(sel), 1'b0);
    if (refuse) begin
      wr(A_CTRL, 32'h0000_0004 | 32'(sel));             // start again while busy
      wr(A_CTRL, 32'(sel));
    end
    n = 0;
    do begin
      expect_q.push_back({1'b1, A_CTRL, 33'h0_0000_0000});
      apb(1'b0, A_CTRL, 32'h0000_0000, rd);
      n++;
    end while (rd[2] !== 1'b0 && n < 40000);
    rd_chk(A_CTRL, 32'(sel), 1'b0);
    rd_chk(A_RESL, {16'h0000, res[15:0]}, 1'b0);
    rd_chk(A_RESH, {16'h0000, res[31:16]}, 1'b0);
    rd_chk(A_STAT, {30'h0000_0000, refuse, 1'b1}, 1'b0);
    check("irq", {32'h0000_0000, irq}, {32'h0000_0000, |(en[1:0] & {refuse, 1'b1})});
    wr(A_CLR, 32'h0000_0003);
    rd_chk(A_STAT, 32'h0000_0000, 1'b0);
    check("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
  endtask : run

  // ----------------------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [11:0] regs[7];
    regs = '{A_CTRL, A_WIN, A_RESL, A_RESH, A_STAT, A_CLR, A_EN};
    void'($urandom(55442));
    miscompares = 0;
    comparisons = 0;
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0000_0000;
    pwdata  = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // reset values of every register, then an unmapped address
    foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000, 1'b0);
    rd_chk(12'h838, 32'h0000_0000, 1'b1);
    // window count is writable, results are read only
    wr(A_WIN, 32'h0000_A5C3);
    rd_chk(A_WIN, 32'h0000_A5C3, 1'b0);
    wr(A_RESL, 32'h0000_FFFF);
    wr(A_RESH, 32'h0000_FFFF);
    rd_chk(A_RESL, 32'h0000_0000, 1'b0);
    rd_chk(A_RESH, 32'h0000_0000, 1'b0);
    // long run carrying into the high half, with a refused restart
    run(3, 4700, 32'h0000_0003, 1'b1);
    // every reference, a zero window first and the last with the interrupt masked
    for (int s = 0; s < 4; s++) begin
      run(s, (s == 0) ? 0 : 1 + int'($urandom % 8), (s == 3) ? 32'h0 : 32'h1, 1'b0);
    end
    repeat (3) @(posedge clk);
    conclude();
  end

endmodule : tb_oscillator_calibration_counter

`default_nettype wire
